// ==== tb/async_serial_transmitter_tb.sv ====
// Purpose: self-checking bench for the serial transmitter
// Assumes: baud register zero gives 32 cycles a bit
// Notes:   reset values from a row table; line cases follow by hand
`include "serial_tx_map.vh"
module async_serial_transmitter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_ref_clk, i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic [3:0]  i_awaddr, i_araddr, i_wstrb, nbits;
   logic [31:0] i_wdata, rd_val;
   logic [1:0]  resp;
   wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_rx_baud_tick;
   wire         o_serial_tx_pin, o_serial_tx_oe, o_tx_irq, rx_stop;
   wire  [1:0]  o_bresp, o_rresp;
   wire  [31:0] o_rdata;
   wire  [8:0]  rx_data;
   int          rx_count, mismatches, total_checks;
   logic [35:0] rows [4] = '{{`STATUS_REG_OFF, 32'hc0}, {`DATA_REG_OFF, 32'h0},
                             {`BAUD_RATE_REG_OFF, 32'h0}, {`CONTROL_REG_ONE_OFF, 32'h40}};

   serial_tx_unit serial_tx_unit_inst (
      .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_awaddr(i_awaddr),
      .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
      .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
      .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready),
      .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
      .o_serial_tx_pin(o_serial_tx_pin), .o_serial_tx_oe(o_serial_tx_oe),
      .o_tx_irq(o_tx_irq), .o_rx_baud_tick(o_rx_baud_tick));
   serial_line_partner serial_line_partner_inst (.i_ref_clk(i_ref_clk),
      .i_line(o_serial_tx_pin), .i_line_oe(o_serial_tx_oe), .i_nbits(nbits),
      .o_data(rx_data), .o_stop(rx_stop), .o_count(rx_count));

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic test_done;
      if (mismatches == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         n++;
         if (i_awvalid && o_awready) i_awvalid <= 1'b0;
         if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1 && n < 200);
      resp = o_bresp;
      i_bready <= 1'b0;
      if (n >= 200) mismatches++;
   endtask

   task automatic rd(input logic [3:0] a);
      int n;
      n = 0;
      @(posedge i_ref_clk);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         n++;
         if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1 && n < 200);
      rd_val = o_rdata;
      i_rready <= 1'b0;
      if (n >= 200) mismatches++;
   endtask

   // Status access then data write, as software must do per character
   task automatic send(input logic [7:0] b);
      rd(`STATUS_REG_OFF);
      wr(`DATA_REG_OFF, {24'h0, b});
   endtask

   task automatic wait_rx(input int k);
      int n;
      for (n = 0; rx_count < k && n < 3000; n++) @(posedge i_ref_clk);
      if (n >= 3000) mismatches++;
   endtask

   initial begin
      i_ref_clk = 1'b0;
      forever #20 i_ref_clk = ~i_ref_clk;
   end

   // Whole run needs about 3500 cycles
   initial begin
      #800000;
      mismatches++;
      test_done;
   end

   initial begin
      {i_reset_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
      {i_awaddr, i_araddr, i_wdata} = '0;
      i_wstrb = 4'hf;
      nbits = 4'd8;
      repeat (16) @(posedge i_ref_clk);
      i_reset_n <= 1'b1;
      foreach (rows[i]) begin
         rd(rows[i][35:32]);
         check("reset value", rows[i][31:0], rd_val);
         check("read resp", 32'h0, o_rresp);
      end
      wr(`BAUD_RATE_REG_OFF, 32'h0);
      wr(`CONTROL_REG_ONE_OFF, 32'h08);
      repeat (2) @(posedge i_ref_clk);
      check("line owned", 32'h1, o_serial_tx_oe);
      check("idle level", 32'h1, o_serial_tx_pin);
      repeat (330) @(posedge i_ref_clk);
      send(8'ha5);
      rd(`STATUS_REG_OFF);
      check("empty after direct load", 32'h80, rd_val & 32'h80);
      wait_rx(1);
      check("byte order", 32'ha5, rx_data);
      check("stop level", 32'h1, rx_stop);
      repeat (20) @(posedge i_ref_clk);
      send(8'h3c);
      send(8'h5a);
      rd(`STATUS_REG_OFF);
      check("flags while held", 32'h0, rd_val);
      wait_rx(2);
      check("first of pair", 32'h3c, rx_data);
      wait_rx(3);
      check("held byte", 32'h5a, rx_data);
      repeat (20) @(posedge i_ref_clk);
      rd(`STATUS_REG_OFF);
      check("flags at end", 32'hc0, rd_val);
      nbits <= 4'd9;
      wr(`CONTROL_REG_ONE_OFF, 32'h0b);
      send(8'h81);
      wait_rx(4);
      check("ninth bit last", 32'h181, rx_data);
      repeat (20) @(posedge i_ref_clk);
      nbits <= 4'd8;
      wr(`CONTROL_REG_ONE_OFF, 32'h0c);
      wait_rx(5);
      check("break data", 32'h0, rx_data);
      check("break stop slot", 32'h0, rx_stop);
      wr(`CONTROL_REG_ONE_OFF, 32'h08);
      send(8'h5f);
      wait_rx(6);
      check("after break", 32'h5f, rx_data);
      wr(`STATUS_REG_OFF, 32'h0);
      check("status write", 32'h2, resp);
      wr(`CONTROL_REG_ONE_OFF, 32'h18);
      repeat (2) @(posedge i_ref_clk);
      check("empty irq", 32'h1, o_tx_irq);
      wr(`CONTROL_REG_ONE_OFF, 32'h58);
      repeat (2) @(posedge i_ref_clk);
      check("masked irq", 32'h0, o_tx_irq);
      repeat (40) @(posedge i_ref_clk);
      send(8'h11);
      send(8'h22);
      wr(`CONTROL_REG_ONE_OFF, 32'h50);
      wr(`CONTROL_REG_ONE_OFF, 32'h58);
      wait_rx(7);
      check("word before toggle", 32'h11, rx_data);
      repeat (700) @(posedge i_ref_clk);
      check("held word dropped", 32'h7, rx_count);
      check("idle after toggle", 32'h1, o_serial_tx_pin);
      test_done;
   end
endmodule

// ==== tb/serial_line_partner.sv ====
// Purpose: far-end receiver that decodes frames from the transmit line
// Assumes: fixed bit length in clock cycles
// Notes:   listens only; samples each bit in its middle
module serial_line_partner #(parameter int BIT_CYCLES = 32) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_line,
   input  wire logic       i_line_oe,
   input  wire logic [3:0] i_nbits,
   output logic [8:0]      o_data,
   output logic            o_stop,
   output int              o_count
);
   logic       prev;
   logic [8:0] word;
   initial begin
      o_data = '0;
      o_stop = 1'b0;
      o_count = 0;
      prev = 1'b1;
      forever begin
         @(posedge i_ref_clk);
         if (i_line_oe && prev && !i_line) begin
            repeat (BIT_CYCLES / 2) @(posedge i_ref_clk);
            word = '0;
            for (int i = 0; i < i_nbits; i++) begin
               repeat (BIT_CYCLES) @(posedge i_ref_clk);
               word[i] = i_line;
            end
            repeat (BIT_CYCLES) @(posedge i_ref_clk);
            o_stop = i_line;
            o_data = word;
            o_count++;
         end
         prev = i_line;
      end
   end
endmodule

// ==== tb/serial_tx_checker_asserts.sv ====
// Purpose: bus and line checks for the serial transmitter
// Assumes: one clock; a bit lasts at least 32 cycles
// Notes:   sees only the ports of serial_tx_unit
`include "serial_tx_map.vh"
module serial_tx_checker (
   // Clock and reset
   input wire logic       i_ref_clk,
   input wire logic       i_reset_n,
   // Register bus
   input wire logic [3:0] i_awaddr,
   input wire logic       i_awvalid,
   input wire logic       o_awready,
   input wire logic       i_wvalid,
   input wire logic       o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic       o_bvalid,
   input wire logic       i_bready,
   input wire logic       i_arvalid,
   input wire logic       o_arready,
   input wire logic       o_rvalid,
   // Serial side
   input wire logic       o_serial_tx_pin,
   input wire logic       o_serial_tx_oe,
   input wire logic       o_rx_baud_tick
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   a_write_answer: assert property (
      i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid) else $error("no write answer");
   a_read_answer: assert property (
      i_arvalid && o_arready |=> o_rvalid) else $error("no read answer");
   a_bresp_hold: assert property (
      o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) else $error("write answer dropped");
   a_status_refused: assert property (
      i_awvalid && o_awready && i_awaddr == `STATUS_REG_OFF && i_wvalid && o_wready
      |-> ##2 o_bresp == `RESP_SLVERR) else $error("status write taken");
   a_enable_idle: assert property (
      $rose(o_serial_tx_oe) |-> o_serial_tx_pin [*8]) else $error("no idle after enable");
   a_low_bit_len: assert property (
      $fell(o_serial_tx_pin) && o_serial_tx_oe |-> !o_serial_tx_pin [*8]) else $error("short low bit");
   a_high_bit_len: assert property (
      $rose(o_serial_tx_pin) && o_serial_tx_oe |-> o_serial_tx_pin [*8]) else $error("short high bit");
   a_rx_tick_pulse: assert property (
      o_rx_baud_tick |=> !o_rx_baud_tick [*8]) else $error("receive tick too close");
endmodule

bind serial_tx_unit serial_tx_checker chk_inst (
   .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
   .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
   .o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready),
   .o_rvalid(o_rvalid), .o_serial_tx_pin(o_serial_tx_pin), .o_serial_tx_oe(o_serial_tx_oe),
   .o_rx_baud_tick(o_rx_baud_tick));

// ==== verilog/serial_tx_map.vh ====
// Purpose: register offsets, field positions, reset values and timing for the serial transmitter
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   byte addresses; unused upper bits read as zero
`ifndef SERIAL_TX_MAP_VH
`define SERIAL_TX_MAP_VH

`define STATUS_REG_OFF       4'h0
`define DATA_REG_OFF         4'h4
`define BAUD_RATE_REG_OFF    4'h8
`define CONTROL_REG_ONE_OFF  4'hc

`define STAT_EMPTY_BIT       7
`define STAT_COMPLETE_BIT    6
`define STATUS_RESET         8'hc0

`define CTL_NINTH_BIT        0
`define CTL_WORD9_BIT        1
`define CTL_BREAK_BIT        2
`define CTL_TX_EN_BIT        3
`define CTL_EMPTY_IE_BIT     4
`define CTL_COMPLETE_IE_BIT  5
`define CTL_GMASK_BIT        6
`define CONTROL_RESET        8'h40

`define BAUD_TX_DIV_LSB      0
`define BAUD_PRESCALE_LSB    3
`define BAUD_RESET           8'h00

`define OVERSAMPLE           32
`define BIT_BASE_DIV1        16'h0020
`define BIT_BASE_DIV3        16'h0060
`define BIT_BASE_DIV4        16'h0080
`define BIT_BASE_DIV13       16'h01a0
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ==== verilog/serial_tx_unit.v ====
// Purpose: transmit side of an asynchronous NRZ serial unit behind an AXI4-Lite slave
// Assumes: one clock i_ref_clk at 25 MHz, asynchronous active-low reset
// Notes:   receive side absent; its baud field in the baud register only sets the o_rx_baud_tick rate
//
// Behaviour
// - Word length is 8 bits when select is clear, 9 when set.
// - Frame is start bit, data word, stop bit; line idle before.
// - Pin low during start bit, high during stop bit.
// - Enabled and idle keeps pin high; disabled hands pin back to port.
// - Idle character is a whole frame of ones.
// - Break is whole zero frames, then one extra one bit.
// - Transmit and receive have separate baud generators.
// - In 9-bit mode the ninth control bit goes out as last data bit.
// - Data leaves LSB first; data register is a holding buffer.
// - Setting transmit enable takes the pin and sends an idle frame first.
// - Buffer-empty clears only by status access then data write.
// - Buffer-empty sets when the holding buffer empties and transfer begins.
// - Buffer-empty interrupts when enabled and global mask clear.
// - Write during a frame waits in holding buffer until frame ends.
// - Write while idle loads shifter, starts, and sets buffer-empty at once.
// - Frame end sets complete flag; interrupts when enabled and unmasked.
// - Transmit and receive dividers are independent, prescaler shared, at most 781250 baud.
// - Complete flag clears by the same status-then-data sequence.
// - Break frames repeat while break bit set; then one one bit.
// - Enable toggle mid-frame sends idle after current word; buffer lost.
//
// The address map and the AXI4-Lite slave port were left to the implementer.

`include "serial_tx_map.vh"

module serial_tx_unit (
   // Clock and reset
   input  wire        i_ref_clk,
   input  wire        i_reset_n,
   // AXI4-Lite write address and data
   input  wire [3:0]  i_awaddr,
   input  wire        i_awvalid,
   output wire        o_awready,
   input  wire [31:0] i_wdata,
   input  wire [3:0]  i_wstrb,
   input  wire        i_wvalid,
   output wire        o_wready,
   // AXI4-Lite write response
   output wire [1:0]  o_bresp,
   output wire        o_bvalid,
   input  wire        i_bready,
   // AXI4-Lite read
   input  wire [3:0]  i_araddr,
   input  wire        i_arvalid,
   output wire        o_arready,
   output wire [31:0] o_rdata,
   output wire [1:0]  o_rresp,
   output wire        o_rvalid,
   input  wire        i_rready,
   // Serial pin, interrupt and receive baud tick
   output wire        o_serial_tx_pin,
   output wire        o_serial_tx_oe,
   output wire        o_tx_irq,
   output wire        o_rx_baud_tick
);

   localparam ST_IDLE  = 2'h0;
   localparam ST_START = 2'h1;
   localparam ST_DATA  = 2'h2;
   localparam ST_STOP  = 2'h3;

   // prescaler times power
   // Cycles per bit: 32 times prescaler times 2^divider
   // Slowest setting is 416 shifted by 7, so 16 bits are needed
   function [15:0] bit_cycles;
      input [1:0]  prescale;
      input [2:0]  divider;
      reg   [15:0] base;
      begin
         case (prescale)
            2'h0:    base = `BIT_BASE_DIV1;
            2'h1:    base = `BIT_BASE_DIV3;
            2'h2:    base = `BIT_BASE_DIV4;
            default: base = `BIT_BASE_DIV13;
         endcase
         bit_cycles = base << divider;
      end
   endfunction

   reg  [7:0]  control_reg_one_ff;
   reg  [7:0]  baud_rate_reg_ff;
   reg         tx_buffer_empty_flag_ff;
   reg         tx_complete_flag_ff;
   reg         status_seen_ff;
   reg  [8:0]  tx_holding_buffer_ff;
   reg         hold_full_ff;
   reg  [9:0]  shift_ff;
   reg  [3:0]  bit_cnt_ff;
   reg  [1:0]  state_ff;
   reg  [15:0] baud_cnt_ff;
   reg  [15:0] rx_baud_cnt_ff;
   reg         pin_ff;
   reg         oe_ff;
   reg         idle_pending_ff;
   reg         break_frame_ff;
   reg         extra_one_ff;
   reg         en_seen_off_ff;
   reg  [3:0]  aw_addr_ff;
   reg         aw_full_ff;
   reg  [31:0] w_data_ff;
   reg  [3:0]  w_strb_ff;
   reg         w_full_ff;
   reg         bvalid_ff;
   reg  [1:0]  bresp_ff;
   reg         rvalid_ff;
   reg  [31:0] rdata_ff;
   reg  [1:0]  rresp_ff;

   wire tx_en    = control_reg_one_ff[`CTL_TX_EN_BIT];
   wire word9    = control_reg_one_ff[`CTL_WORD9_BIT];
   wire brk      = control_reg_one_ff[`CTL_BREAK_BIT];
   wire do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
   wire wr_data  = do_write & (aw_addr_ff == `DATA_REG_OFF) & w_strb_ff[0];
   wire wr_ctl   = do_write & (aw_addr_ff == `CONTROL_REG_ONE_OFF) & w_strb_ff[0];
   wire wr_baud  = do_write & (aw_addr_ff == `BAUD_RATE_REG_OFF) & w_strb_ff[0];
   wire rd_take  = i_arvalid & ~rvalid_ff;
   wire rd_stat  = rd_take & (i_araddr == `STATUS_REG_OFF);
   wire seq_clr  = wr_data & status_seen_ff;
   wire [15:0] tx_period = bit_cycles(baud_rate_reg_ff[`BAUD_PRESCALE_LSB +: 2],
                                      baud_rate_reg_ff[`BAUD_TX_DIV_LSB +: 3]);
   wire [15:0] rx_period = bit_cycles(baud_rate_reg_ff[`BAUD_PRESCALE_LSB +: 2],
                                      baud_rate_reg_ff[7:5]);
   wire bit_end  = (baud_cnt_ff == tx_period - 16'h0001);
   wire [3:0] last_bit = word9 ? 4'h8 : 4'h7;
   wire frame_end = (state_ff == ST_STOP) & bit_end;
   wire line_free = (state_ff == ST_IDLE) | frame_end;
   // Writes wait in the buffer while a frame or an idle frame is due
   wire hold_in   = wr_data & (state_ff != ST_IDLE | idle_pending_ff | ~tx_en);
   wire hold_load = hold_full_ff & line_free & tx_en & ~brk & ~idle_pending_ff & ~extra_one_ff &
                    ~(frame_end & break_frame_ff);

   assign o_awready = ~aw_full_ff;
   assign o_wready  = ~w_full_ff;
   assign o_bvalid  = bvalid_ff;
   assign o_bresp   = bresp_ff;
   assign o_arready = ~rvalid_ff;
   assign o_rvalid  = rvalid_ff;
   assign o_rdata   = rdata_ff;
   assign o_rresp   = rresp_ff;
   assign o_serial_tx_pin = pin_ff;
   assign o_serial_tx_oe  = oe_ff;
   assign o_rx_baud_tick  = (rx_baud_cnt_ff == 16'h0000);
   assign o_tx_irq = ~control_reg_one_ff[`CTL_GMASK_BIT] &
                     ((tx_buffer_empty_flag_ff & control_reg_one_ff[`CTL_EMPTY_IE_BIT]) |
                      (tx_complete_flag_ff & control_reg_one_ff[`CTL_COMPLETE_IE_BIT]));

   // Bus slave: address and data may arrive in either order
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         aw_addr_ff <= 4'h0;
         aw_full_ff <= 1'b0;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
         w_full_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `RESP_OKAY;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `RESP_OKAY;
      end else begin
         if (i_awvalid & ~aw_full_ff) begin
            aw_addr_ff <= {i_awaddr[3:2], 2'h0};
            aw_full_ff <= 1'b1;
         end
         if (i_wvalid & ~w_full_ff) begin
            w_data_ff <= i_wdata;
            w_strb_ff <= i_wstrb;
            w_full_ff <= 1'b1;
         end
         if (do_write) begin
            aw_full_ff <= 1'b0;
            w_full_ff  <= 1'b0;
            bvalid_ff  <= 1'b1;
            bresp_ff   <= (aw_addr_ff == `STATUS_REG_OFF) ? `RESP_SLVERR : `RESP_OKAY;
         end else if (bvalid_ff & i_bready) begin
            bvalid_ff <= 1'b0;
         end
         if (rd_take) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= `RESP_OKAY;
            case ({i_araddr[3:2], 2'h0})
               `STATUS_REG_OFF:
                  rdata_ff <= {24'h0, tx_buffer_empty_flag_ff, tx_complete_flag_ff, 6'h00};
               `DATA_REG_OFF:        rdata_ff <= 32'h0000_0000;
               `BAUD_RATE_REG_OFF:   rdata_ff <= {24'h0, baud_rate_reg_ff};
               default:              rdata_ff <= {24'h0, control_reg_one_ff};
            endcase
         end else if (rvalid_ff & i_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   // Registers and flags
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         control_reg_one_ff      <= `CONTROL_RESET;
         baud_rate_reg_ff        <= `BAUD_RESET;
         status_seen_ff          <= 1'b0;
         tx_buffer_empty_flag_ff <= 1'b1;
         tx_complete_flag_ff     <= 1'b1;
      end else begin
         if (wr_ctl) begin
            control_reg_one_ff <= w_data_ff[7:0];
         end
         // Rate change while enabled is on software, as with any divider
         if (wr_baud) begin
            baud_rate_reg_ff <= w_data_ff[7:0];
         end
         // Status read arms the clear; a data write to byte 0 disarms it unless a status read comes in the same cycle
         if (rd_stat) begin
            status_seen_ff <= 1'b1;
         end else if (wr_data) begin
            status_seen_ff <= 1'b0;
         end
         if (wr_data & ~hold_in) begin
            tx_buffer_empty_flag_ff <= 1'b1;
         end else if (hold_load) begin
            tx_buffer_empty_flag_ff <= 1'b1;
         end else if (seq_clr) begin
            tx_buffer_empty_flag_ff <= 1'b0;
         end
         if (frame_end) begin
            tx_complete_flag_ff <= 1'b1;
         end else if (seq_clr) begin
            tx_complete_flag_ff <= 1'b0;
         end
      end
   end

   // Transmit state machine
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_ff             <= ST_IDLE;
         shift_ff             <= 10'h3ff;
         bit_cnt_ff           <= 4'h0;
         baud_cnt_ff          <= 16'h0000;
         rx_baud_cnt_ff       <= 16'h0000;
         pin_ff               <= 1'b1;
         oe_ff                <= 1'b0;
         tx_holding_buffer_ff <= 9'h000;
         hold_full_ff         <= 1'b0;
         idle_pending_ff      <= 1'b0;
         break_frame_ff       <= 1'b0;
         extra_one_ff         <= 1'b0;
         en_seen_off_ff       <= 1'b1;
      end else begin
         // Receive tick runs free; it stands in for the absent receiver
         rx_baud_cnt_ff <= (rx_baud_cnt_ff >= rx_period - 16'h0001) ? 16'h0000
                           : rx_baud_cnt_ff + 16'h0001;
         en_seen_off_ff <= ~tx_en;
         if (tx_en & en_seen_off_ff) begin
            idle_pending_ff <= 1'b1;
            hold_full_ff    <= 1'b0;
         end
         // Pin stays owned after disable until the frame in progress ends
         // pin ownership
         oe_ff <= tx_en | (state_ff != ST_IDLE);
         if (hold_in) begin
            tx_holding_buffer_ff <= {control_reg_one_ff[`CTL_NINTH_BIT], w_data_ff[7:0]};
            hold_full_ff         <= 1'b1;
         end
         baud_cnt_ff <= (state_ff == ST_IDLE | bit_end) ? 16'h0000 : baud_cnt_ff + 16'h0001;
         case (state_ff)
            ST_START: begin
               if (bit_end) begin
                  state_ff   <= ST_DATA;
                  bit_cnt_ff <= 4'h0;
                  pin_ff     <= shift_ff[0];
               end
            end
            ST_DATA: begin
               if (bit_end) begin
                  if (bit_cnt_ff == last_bit) begin
                     state_ff <= ST_STOP;
                     pin_ff   <= ~break_frame_ff;
                  end else begin
                     bit_cnt_ff <= bit_cnt_ff + 4'h1;
                     shift_ff   <= {1'b1, shift_ff[9:1]};
                     pin_ff     <= shift_ff[1];
                  end
               end
            end
            default: begin
               if (state_ff == ST_IDLE | frame_end) begin
                  state_ff <= ST_IDLE;
                  pin_ff   <= 1'b1;
                  if (frame_end) begin
                     extra_one_ff <= break_frame_ff;
                  end
                  // Break bit is only looked at between frames
                  break_frame_ff <= 1'b0;
                  if (tx_en & brk) begin
                     state_ff       <= ST_START;
                     pin_ff         <= 1'b0;
                     shift_ff       <= 10'h000;
                     break_frame_ff <= 1'b1;
                  end else if (extra_one_ff | (frame_end & break_frame_ff)) begin
                     state_ff     <= ST_STOP;
                     extra_one_ff <= 1'b0;
                  end else if (tx_en & idle_pending_ff) begin
                     state_ff        <= ST_START;
                     pin_ff          <= 1'b1;
                     shift_ff        <= 10'h3ff;
                     idle_pending_ff <= 1'b0;
                  end else if (tx_en & hold_full_ff) begin
                     state_ff     <= ST_START;
                     pin_ff       <= 1'b0;
                     shift_ff     <= {1'b1, tx_holding_buffer_ff};
                     hold_full_ff <= 1'b0;
                  end else if (tx_en & wr_data & ~hold_in) begin
                     state_ff <= ST_START;
                     pin_ff   <= 1'b0;
                     shift_ff <= {1'b1, control_reg_one_ff[`CTL_NINTH_BIT], w_data_ff[7:0]};
                  end
               end
            end
         endcase
      end
   end

endmodule
